// [pao_pkg.sv]
package pao_pkg;
    localparam int DATA_W = 14;
    localparam int WORD_W = DATA_W + 1;
    localparam int LATENCY = 12;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_HZ = 20000000;
    // Code map anchor points
    localparam logic [DATA_W-1:0] CODE_MIN = 14'h0000;
    localparam logic [DATA_W-1:0] CODE_MID = 14'h2000;
    localparam logic [DATA_W-1:0] CODE_MAX = 14'h3FFF;
    localparam logic [DATA_W-1:0] SE_MIN = 14'h1000;
    localparam logic [DATA_W-1:0] SE_MAX = 14'h3000;
    localparam logic [DATA_W-1:0] RESET_CODE = 14'h0000;
    // Raw quantiser input: signed 16-bit sample, 16'sh2000 is full scale
    localparam int RAW_W = 16;
    localparam logic signed [RAW_W-1:0] RAW_FS = 16'sh2000;
    localparam logic [$clog2(LATENCY+1)-1:0] FLUSH_CNT = 4'hC;
    typedef struct packed {
        logic out_of_range;
        logic [DATA_W-1:0] result;
    } pao_word_type;
endpackage

// [pao_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module pao_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // Pointer and count update; pop and push may share a cycle
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = AW'(0) + cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; out_valid guards its contents
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule
`default_nettype wire

// [pao_top.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Fifteen outputs: 14-bit result plus range
// - Result is unsigned straight binary
// - Differential map: zeros, mid 10..0, ones
// - Single-ended codes span 01..0 to 11..0
// - One output word every clock cycle
// - Input sampled on rising clock edge
// - Result appears twelve cycles after sampling
// - Power-down high holds low-power state
// - Pipeline contents corrupted by power-down
// - Output enable switches drive versus release
// - Enable polarity conflicting; parameter selects it
// - Range flag set beyond convertible range
module pao_top #(
    // 1: outputs drive while OUTPUT_EN is high; 0: drive while low
    parameter bit OE_ACTIVE_HIGH = 1'b1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Quantiser front end: signed difference, valid each edge
    input wire logic signed [pao_pkg::RAW_W-1:0] SAMPLE_DIFF,
    input wire logic SINGLE_ENDED,
    // Pins from the capture side
    input wire logic POWER_DOWN_INPUT,
    input wire logic OUTPUT_EN,
    // Output word and its drive enable
    output pao_pkg::pao_word_type WORD_OUT,
    output logic WORD_OE,
    output logic WORD_VALID
);
    // FIFO slot and output register supply the last two cycles of latency
    localparam int L = pao_pkg::LATENCY - 1;
    localparam int CW = $clog2(L + 1);

    // Pin synchronisers; first stage is read only by the second
    logic pd_s1_reg, pd_s2_reg, oe_s1_reg, oe_s2_reg;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pd_s1_reg <= 1'b1;
            pd_s2_reg <= 1'b1;
            oe_s1_reg <= 1'b0;
            oe_s2_reg <= 1'b0;
        end else begin
            pd_s1_reg <= POWER_DOWN_INPUT;
            pd_s2_reg <= pd_s1_reg;
            oe_s1_reg <= OUTPUT_EN;
            oe_s2_reg <= oe_s1_reg;
        end
    end

    // Quantise: clip and map to straight binary
    pao_pkg::pao_word_type q_word;
    logic signed [pao_pkg::RAW_W-1:0] scaled;
    logic signed [pao_pkg::RAW_W:0] biased;
    logic signed [pao_pkg::RAW_W-1:0] limit;
    always_comb begin
        biased = '0;
        // Single-ended drive sees half the swing and half the range
        scaled = SINGLE_ENDED ? (SAMPLE_DIFF >>> 1) : SAMPLE_DIFF;
        limit = SINGLE_ENDED ? (pao_pkg::RAW_FS >>> 1) : pao_pkg::RAW_FS;
        q_word.out_of_range = 1'b0;
        if (scaled >= limit) begin
            q_word.out_of_range = 1'b1;
            q_word.result = pao_pkg::CODE_MAX;
        end else if (scaled < -limit) begin
            q_word.out_of_range = 1'b1;
            q_word.result = pao_pkg::CODE_MIN;
        end else begin
            // Offset binary: add mid code, no sign bit kept
            biased = (pao_pkg::RAW_W+1)'(scaled) + (pao_pkg::RAW_W+1)'(pao_pkg::CODE_MID);
            q_word.result = biased[pao_pkg::DATA_W-1:0];
        end
        if (q_word.out_of_range && SINGLE_ENDED) begin
            // Single-ended span stops at quarter and three quarter codes
            q_word.result = q_word.result[pao_pkg::DATA_W-1] ? pao_pkg::SE_MAX
                                                            : pao_pkg::SE_MIN;
        end
        if (!q_word.out_of_range && SINGLE_ENDED) begin
            q_word.result = q_word.result;
        end
    end

    // Eleven-stage pipeline: sample taken on rising edge, one word per clock
    pao_pkg::pao_word_type pipe_reg [L];
    pao_pkg::pao_word_type pipe_next [L];
    logic [CW-1:0] flush_reg, flush_next;
    always_comb begin
        pipe_next[0] = q_word;
        for (int i = 1; i < L; i++) begin
            pipe_next[i] = pipe_reg[i-1];
        end
        flush_next = flush_reg;
        if (pd_s2_reg) begin
            // Contents in flight are lost; blank the pipe
            for (int i = 0; i < L; i++) begin
                pipe_next[i] = '0;
            end
            flush_next = pao_pkg::FLUSH_CNT;
        end else if (flush_reg != '0) begin
            flush_next = CW'(flush_reg - 1'b1);
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < L; i++) begin
                pipe_reg[i] <= '0;
            end
            flush_reg <= pao_pkg::FLUSH_CNT;
        end else begin
            for (int i = 0; i < L; i++) begin
                pipe_reg[i] <= pipe_next[i];
            end
            flush_reg <= flush_next;
        end
    end

    // Output FIFO of four words; drain always ready so word rate equals clock
    pao_pkg::pao_word_type fifo_out;
    logic fifo_valid, fifo_in_ready;
    pao_fifo #(
        .WIDTH(pao_pkg::WORD_W),
        .DEPTH(pao_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .arst_n(ARST_N),
        .in_valid(!pd_s2_reg && fifo_in_ready),
        .in_ready(fifo_in_ready),
        .in_data(pipe_reg[L-1]),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_out)
    );

    // Output register: low-power state parks the word at zero
    pao_pkg::pao_word_type word_reg, word_next;
    logic valid_reg, valid_next;
    always_comb begin
        word_next = word_reg;
        valid_next = 1'b0;
        if (pd_s2_reg) begin
            word_next = '0;
        end else if (fifo_valid) begin
            word_next = fifo_out;
            valid_next = (flush_reg == '0);
        end
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            word_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            word_reg <= word_next;
            valid_reg <= valid_next;
        end
    end

    assign WORD_OUT = word_reg;
    assign WORD_VALID = valid_reg;
    // Polarity is a parameter because the two descriptions disagree
    assign WORD_OE = (oe_s2_reg == OE_ACTIVE_HIGH);
endmodule
`default_nettype wire

// [pao_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module pao_assertions (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Front end and pins
    input wire logic signed [pao_pkg::RAW_W-1:0] SAMPLE_DIFF,
    input wire logic SINGLE_ENDED,
    input wire logic POWER_DOWN_INPUT,
    input wire logic OUTPUT_EN,
    // Output word
    input wire pao_pkg::pao_word_type WORD_OUT,
    input wire logic WORD_OE,
    input wire logic WORD_VALID
);
    logic [1:0] age_reg;
    logic [1:0] age_next;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // Age since reset: the enable sync holds stale zeros for two edges
    always_comb age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) age_reg <= 2'h0;
        else age_reg <= age_next;
    end
    property p_oe;
        age_reg == 2'h3 |-> WORD_OE == $past(OUTPUT_EN, 2);
    endproperty
    a_oe: assert property (p_oe) else $error("drive enable wrong");
    property p_pd;
        POWER_DOWN_INPUT [*4] |=> !WORD_VALID;
    endproperty
    a_pd: assert property (p_pd) else $error("valid in power-down");
    property p_flush;
        $fell(POWER_DOWN_INPUT) |-> !WORD_VALID [*8] ##1 !WORD_VALID [*5];
    endproperty
    a_flush: assert property (p_flush) else $error("stale word valid");
    property p_run;
        !POWER_DOWN_INPUT [*3] ##0 WORD_VALID |=> WORD_VALID;
    endproperty
    a_run: assert property (p_run) else $error("word stream gap");
    property p_mid;
        WORD_VALID && !$past(SINGLE_ENDED, 13) && $past(SAMPLE_DIFF, 13) == 16'sh0000
            |-> WORD_OUT == {1'b0, pao_pkg::CODE_MID};
    endproperty
    a_mid: assert property (p_mid) else $error("mid code wrong");
    property p_over;
        WORD_VALID && !$past(SINGLE_ENDED, 13) && $past(SAMPLE_DIFF, 13) >= pao_pkg::RAW_FS
            |-> WORD_OUT == {1'b1, pao_pkg::CODE_MAX};
    endproperty
    a_over: assert property (p_over) else $error("over range wrong");
    property p_under;
        WORD_VALID && !$past(SINGLE_ENDED, 13) && $past(SAMPLE_DIFF, 13) < -pao_pkg::RAW_FS
            |-> WORD_OUT == {1'b1, pao_pkg::CODE_MIN};
    endproperty
    a_under: assert property (p_under) else $error("under range wrong");
    property p_se;
        WORD_VALID && $past(SINGLE_ENDED, 13)
            |-> WORD_OUT.result inside {[pao_pkg::SE_MIN:pao_pkg::SE_MAX]};
    endproperty
    a_se: assert property (p_se) else $error("single-ended span wrong");
endmodule
bind pao_top pao_assertions u_pao_chk (.CLK(CLK), .ARST_N(ARST_N), .SAMPLE_DIFF(SAMPLE_DIFF),
    .SINGLE_ENDED(SINGLE_ENDED), .POWER_DOWN_INPUT(POWER_DOWN_INPUT), .OUTPUT_EN(OUTPUT_EN),
    .WORD_OUT(WORD_OUT), .WORD_OE(WORD_OE), .WORD_VALID(WORD_VALID));
`default_nettype wire

// [pao_capture.sv]
`timescale 1ns/10ps
`default_nettype none
module pao_capture (
    // Clock and word pins
    input wire logic clk,
    input wire pao_pkg::pao_word_type word,
    input wire logic word_oe,
    input wire logic word_valid,
    input wire logic pd,
    // Captured word
    output pao_pkg::pao_word_type cap_word,
    output logic cap_vld,
    output logic cap_over
);
    int skip = 0;
    // Latch mid-cycle, away from the rising-edge output change
    always @(negedge clk) begin
        cap_vld <= 1'b0;
        if (pd) begin
            skip = 12;
        end else if (skip > 0) begin
            skip = skip - 1;
        end else if (word_oe && word_valid) begin
            cap_word <= word;
            cap_vld <= 1'b1;
            cap_over <= word.out_of_range && word.result[pao_pkg::DATA_W-1];
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic signed [pao_pkg::RAW_W-1:0] diff = 16'sh0000;
    logic se = 1'b0;
    logic pd = 1'b0;
    logic oe_in = 1'b1;
    pao_pkg::pao_word_type word;
    pao_pkg::pao_word_type cap_word;
    logic word_oe, word_valid, cap_vld, cap_over;
    int fails = 0;
    int checks_done = 0;
    int ticks = 0;
    int quiet = 0;
    int q[$];
    int tbl[8] = '{-8193, -8192, 0, 8190, 8191, 8192, -12288, 12286};
    pao_top DUT (.CLK(clk), .ARST_N(arst_n), .SAMPLE_DIFF(diff), .SINGLE_ENDED(se),
        .POWER_DOWN_INPUT(pd), .OUTPUT_EN(oe_in), .WORD_OUT(word), .WORD_OE(word_oe),
        .WORD_VALID(word_valid));
    pao_capture u_cap (.clk(clk), .word(word), .word_oe(word_oe), .word_valid(word_valid),
        .pd(pd), .cap_word(cap_word), .cap_vld(cap_vld), .cap_over(cap_over));
    // Free-running conversion clock, never paused
    initial forever #25 clk = ~clk;
    function automatic int expw(int d, logic s);
        int c;
        c = s ? 8192 + d / 2 : 8192 + d;
        // Single-ended clips to the quarter and three-quarter codes
        if (s && d >= 8192) return 28672;
        if (s && d < -8192) return 20480;
        if (c < 0) return 16384;
        if (c > 16383) return 32767;
        return c;
    endfunction
    task automatic conclude();
        if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(int e);
        checks_done++;
        if (cap_vld !== 1'b1 || cap_word !== e[14:0] || cap_over !== (e[14] & e[13])) begin
            fails++;
            $display("mismatch %0t word exp %h got %h", $time, e[14:0], cap_word);
        end
    endtask
    task automatic chk(logic got, logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t level exp %b got %b", $time, exp, got);
        end
    endtask
    task automatic put(int d, logic s);
        @(posedge clk);
        #1;
        diff = d[15:0];
        se = s;
    endtask
    task automatic run(int n, int m);
        int d;
        logic s;
        repeat (n) begin
            d = int'($urandom % 24576) - 12288;
            s = (m == 2) ? 1'($urandom % 2) : 1'(m);
            put(s ? (d * 2 / 3) & -2 : d, s);
        end
    endtask
    // Model: words sampled 13 edges back; in-flight words void on any upset
    always @(posedge clk) begin
        ticks++;
        if (ticks > 2000) begin
            fails++;
            conclude();
        end
        if (!arst_n || pd || !oe_in) begin
            quiet = 20;
            foreach (q[i]) q[i] = -1;
        end else if (quiet > 0) quiet--;
        q.push_back(quiet > 0 ? -1 : expw(diff, se));
        if (q.size() > 13 && q[0] >= 0) cmp(q[0]);
        if (q.size() > 13) void'(q.pop_front());
    end
    initial begin
        void'($urandom(1500));
        repeat (12) @(posedge clk);
        #1;
        chk(word_oe, 1'b0);
        arst_n = 1'b1;
        run(300, 0);
        foreach (tbl[i]) put(tbl[i], 1'b0);
        put(-8192, 1'b1);
        put(8190, 1'b1);
        put(9000, 1'b1);
        put(-9000, 1'b1);
        run(200, 1);
        run(200, 2);
        pd = 1'b1;
        run(30, 2);
        pd = 1'b0;
        run(100, 2);
        oe_in = 1'b0;
        run(20, 0);
        chk(word_oe, 1'b0);
        oe_in = 1'b1;
        run(40, 0);
        arst_n = 1'b0;
        run(3, 0);
        chk(word_oe, 1'b0);
        arst_n = 1'b1;
        run(100, 2);
        conclude();
    end
endmodule
`default_nettype wire
